/* verilog/radio_spi_defs.vh */
// Shared constants for the radio serial control port host controller
`ifndef RADIO_SPI_DEFS_VH
`define RADIO_SPI_DEFS_VH

// ============================================================
// Clock and link timing
// ============================================================
`define CLK_PERIOD_NS 40
`define T_CS_SETUP_NS 125
`define T_CS_HOLD_NS 125
`define T_CS_IDLE_NS 125
// Least times round up to whole cycles
`define CS_SETUP_CYC ((`T_CS_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CS_HOLD_CYC ((`T_CS_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CS_IDLE_CYC ((`T_CS_IDLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Half periods of the serial clock in system cycles (normal, low power)
`define SCK_HALF_CYC 3
`define SCK_HALF_SLOW_CYC 13

// ============================================================
// Frame layout
// ============================================================
`define RW_READ 1'b1
`define RW_WRITE 1'b0
`define LAST_BIT 3'h7
`define FILL_BYTE 8'h00

// ============================================================
// Register map of the device and start-up values
// ============================================================
`define ADDR_STATUS_PRIMARY 7'h00
`define STATUS_CLEAR_ALL 8'hff
`define POWER_STANDBY 8'h00
`define CAL_CHANNEL 8'h13
`define INIT_LAST_STEP 2'h3

`endif

/* verilog/sck_tick_gen.v */
// Serial clock half-period enable generator
`timescale 1ns/1ps
`default_nettype none

module sck_tick_gen #(
    parameter HALF = 3,
    parameter HALF_SLOW = 13
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // Control
    input wire run_i,
    input wire slow_i,
    // Enable pulse
    output reg tick_o
);

    // ============================================================
    // Divider
    // ============================================================
    reg [4:0] cnt_ff; // Cycles into the current half period
    wire [4:0] limit; // Last count of a half period
    localparam [31:0] HALF_LAST = HALF - 1; // Last count, normal rate
    localparam [31:0] HALF_SLOW_LAST = HALF_SLOW - 1; // Last count, slow rate

    // Counter is five bits wide, so only the low bits of each limit matter
    assign limit = slow_i ? HALF_SLOW_LAST[4:0] : HALF_LAST[4:0];

    // Count while running, pulse once per half period
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_ff <= 5'h00;
            tick_o <= 1'b0;
        end else if (!run_i) begin
            cnt_ff <= 5'h00;
            tick_o <= 1'b0;
        end else if (cnt_ff >= limit) begin
            cnt_ff <= 5'h00;
            tick_o <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 5'h01;
            tick_o <= 1'b0;
        end
    end

endmodule
`default_nettype wire

/* verilog/radio_spi_host.v */
// Host-side serial control port master for the radio transceiver
`timescale 1ns/1ps
`default_nettype none
`include "radio_spi_defs.vh"

// Overview of operation
// - Frame each access with chip select low
// - First bit: one reads, zero writes
// - Seven address bits, then data bytes
// - Every byte goes most significant first
// - Read: command byte plus data bytes
// - Write: command byte plus data bytes
// - Single byte frame returns only status
// - Change data on fall, sample on rise
// - Host clears reset flag after power-up
// - Writing 0x00 returns to standby
// - Host calibrates on channel 19 after reset
module radio_spi_host #(
    parameter ADDR_POWER = 7'h01,
    parameter ADDR_CHANNEL = 7'h02,
    parameter ADDR_SETUP = 7'h03,
    parameter CAL_REQ_VALUE = 8'h01
) (
    // Clock and reset
    input wire ref_clk_i,
    input wire arst_n_i,
    // User command port
    input wire cmd_valid_i,
    input wire cmd_read_i,
    input wire [6:0] cmd_addr_i,
    input wire [5:0] cmd_len_i,
    input wire slow_link_i,
    output reg cmd_ready_o,
    output reg done_o,
    // User write data
    input wire [7:0] wr_data_i,
    output reg wr_take_o,
    // User read data and status
    output reg [7:0] rd_data_o,
    output reg rd_valid_o,
    output reg [7:0] status_o,
    output reg status_valid_o,
    output reg init_done_o,
    // Interrupt pin
    input wire irq_pin_i,
    input wire irq_active_low_i,
    output reg irq_o,
    // Serial link pins
    output reg csn_o,
    output reg sck_o,
    output reg sdi_o,
    input wire sdo_i
);

    // ============================================================
    // States
    // ============================================================
    localparam ST_IDLE = 3'h0;
    localparam ST_SETUP = 3'h1;
    localparam ST_SHIFT = 3'h2;
    localparam ST_HOLD = 3'h3;
    localparam ST_GAP = 3'h4;

    // ============================================================
    // Start-up sequence table
    // ============================================================
    // Address and data written at each start-up step
    function [14:0] init_word;
        input [1:0] step;
        begin
            case (step)
                2'h0: init_word = {ADDR_POWER, `POWER_STANDBY};
                2'h1: init_word = {`ADDR_STATUS_PRIMARY, `STATUS_CLEAR_ALL};
                2'h2: init_word = {ADDR_CHANNEL, `CAL_CHANNEL};
                default: init_word = {ADDR_SETUP, CAL_REQ_VALUE};
            endcase
        end
    endfunction

    // ============================================================
    // Reset release and pin synchronisers
    // ============================================================
    reg [1:0] rst_sync_ff; // Reset release chain
    wire rst_n; // Synchronised reset
    reg [1:0] pin_meta_ff; // First stage for sdo and irq
    reg [1:0] pin_sync_ff; // Second stage for sdo and irq
    wire sdo_s; // Synchronised data-out
    wire irq_s; // Synchronised interrupt pin

    // Release reset through two flops
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_sync_ff <= 2'b00;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // Two-flop synchronisers for pin inputs
    always @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_ff <= 2'b00;
            pin_sync_ff <= 2'b00;
        end else begin
            pin_meta_ff <= {irq_pin_i, sdo_i};
            pin_sync_ff <= pin_meta_ff;
        end
    end
    assign sdo_s = pin_sync_ff[0];
    assign irq_s = pin_sync_ff[1];

    // ============================================================
    // Serial clock enable
    // ============================================================
    reg [2:0] state_ff; // Frame state
    reg slow_ff; // Rate captured for the frame
    wire tick; // Half-period enable

    sck_tick_gen #(
        .HALF(`SCK_HALF_CYC),
        .HALF_SLOW(`SCK_HALF_SLOW_CYC)
    ) u_tick (
        .clk_i(ref_clk_i),
        .rst_n_i(rst_n),
        .run_i(state_ff == ST_SHIFT),
        .slow_i(slow_ff),
        .tick_o(tick)
    );

    // ============================================================
    // Frame engine
    // ============================================================
    reg [3:0] cnt_ff; // Setup, hold and gap counter
    reg [7:0] tx_sr_ff; // Bits still to send
    reg [7:0] rx_sr_ff; // Bits received so far
    reg [2:0] bit_ff; // Bit index within byte
    reg [5:0] left_ff; // Data bytes still to move
    reg read_ff; // Frame is a read
    reg first_ff; // Command byte in flight
    reg end_ff; // Last byte sampled
    reg from_init_ff; // Frame belongs to start-up
    reg [7:0] init_data_ff; // Start-up data byte
    reg [1:0] init_step_ff; // Start-up step
    wire [14:0] iw; // Current start-up word
    wire [7:0] rx_byte; // Byte completed on this rise
    wire [7:0] cmd_byte; // Command byte to start

    assign iw = init_word(init_step_ff);
    assign rx_byte = {rx_sr_ff[6:0], sdo_s};
    // Read flag leads, address follows
    assign cmd_byte = init_done_o ? {cmd_read_i ? `RW_READ : `RW_WRITE, cmd_addr_i}
                                  : {`RW_WRITE, iw[14:8]};

    // Main frame sequencer
    always @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
            cnt_ff <= 4'h0;
            tx_sr_ff <= 8'h00;
            rx_sr_ff <= 8'h00;
            bit_ff <= 3'h0;
            left_ff <= 6'h00;
            read_ff <= 1'b0;
            first_ff <= 1'b0;
            end_ff <= 1'b0;
            from_init_ff <= 1'b0;
            init_data_ff <= 8'h00;
            init_step_ff <= 2'h0;
            slow_ff <= 1'b0;
            csn_o <= 1'b1;
            sck_o <= 1'b0;
            sdi_o <= 1'b0;
            cmd_ready_o <= 1'b0;
            done_o <= 1'b0;
            wr_take_o <= 1'b0;
            rd_data_o <= 8'h00;
            rd_valid_o <= 1'b0;
            status_o <= 8'h00;
            status_valid_o <= 1'b0;
            init_done_o <= 1'b0;
        end else begin
            // Pulses default low
            done_o <= 1'b0;
            wr_take_o <= 1'b0;
            rd_valid_o <= 1'b0;
            status_valid_o <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    // Start-up frames first, then user frames
                    if (!init_done_o || (cmd_valid_i && cmd_ready_o)) begin
                        cmd_ready_o <= 1'b0;
                        csn_o <= 1'b0;
                        sdi_o <= cmd_byte[7];
                        tx_sr_ff <= {cmd_byte[6:0], 1'b0};
                        read_ff <= init_done_o & cmd_read_i;
                        left_ff <= init_done_o ? cmd_len_i : 6'h01;
                        from_init_ff <= ~init_done_o;
                        init_data_ff <= iw[7:0];
                        slow_ff <= slow_link_i;
                        first_ff <= 1'b1;
                        end_ff <= 1'b0;
                        bit_ff <= 3'h0;
                        cnt_ff <= 4'h0;
                        state_ff <= ST_SETUP;
                    end else begin
                        cmd_ready_o <= 1'b1;
                    end
                end
                ST_SETUP: begin
                    // Chip select leads the first clock edge
                    if (cnt_ff >= `CS_SETUP_CYC - 1) begin
                        state_ff <= ST_SHIFT;
                    end else begin
                        cnt_ff <= cnt_ff + 4'h1;
                    end
                end
                ST_SHIFT: begin
                    if (tick && !sck_o) begin
                        // Rising edge: sample data-out
                        sck_o <= 1'b1;
                        rx_sr_ff <= rx_byte;
                        bit_ff <= bit_ff + 3'h1;
                        if (bit_ff == `LAST_BIT) begin
                            // Whole byte done
                            first_ff <= 1'b0;
                            if (first_ff) begin
                                status_o <= rx_byte;
                                status_valid_o <= 1'b1;
                            end else if (read_ff) begin
                                rd_data_o <= rx_byte;
                                rd_valid_o <= 1'b1;
                            end
                            if (left_ff == 6'h00) begin
                                end_ff <= 1'b1;
                            end else begin
                                left_ff <= left_ff - 6'h01;
                                if (read_ff) begin
                                    tx_sr_ff <= `FILL_BYTE;
                                end else if (from_init_ff) begin
                                    tx_sr_ff <= init_data_ff;
                                end else begin
                                    tx_sr_ff <= wr_data_i;
                                    wr_take_o <= 1'b1;
                                end
                            end
                        end
                    end else if (tick) begin
                        // Falling edge: next data-in bit
                        sck_o <= 1'b0;
                        if (end_ff) begin
                            cnt_ff <= 4'h0;
                            state_ff <= ST_HOLD;
                        end else begin
                            sdi_o <= tx_sr_ff[7];
                            tx_sr_ff <= {tx_sr_ff[6:0], 1'b0};
                        end
                    end
                end
                ST_HOLD: begin
                    // Clock settles before chip select rises
                    if (cnt_ff >= `CS_HOLD_CYC - 1) begin
                        csn_o <= 1'b1;
                        sdi_o <= 1'b0;
                        cnt_ff <= 4'h0;
                        state_ff <= ST_GAP;
                    end else begin
                        cnt_ff <= cnt_ff + 4'h1;
                    end
                end
                ST_GAP: begin
                    // Least chip select inactive time
                    if (cnt_ff >= `CS_IDLE_CYC - 1) begin
                        state_ff <= ST_IDLE;
                        if (from_init_ff) begin
                            // Step through standby, flag clear, channel, calibrate
                            if (init_step_ff == `INIT_LAST_STEP) begin
                                init_done_o <= 1'b1;
                            end else begin
                                init_step_ff <= init_step_ff + 2'h1;
                            end
                        end else begin
                            done_o <= 1'b1;
                        end
                    end else begin
                        cnt_ff <= cnt_ff + 4'h1;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // ============================================================
    // Interrupt pin decode
    // ============================================================
    // Normalise pin level to active high
    always @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= irq_s ^ irq_active_low_i;
        end
    end

endmodule
`default_nettype wire

/* verif/radio_dev_model.sv */
// Behavioural model of the radio device behind the serial control port
`timescale 1ns/1ps
`default_nettype none
module radio_dev_model (
    // Serial link pins
    input wire logic csn_i,
    input wire logic sck_i,
    input wire logic sdi_i,
    output logic sdo_o,
    // Interrupt pin
    output wire logic irq_o
);
    // ============================================================
    // Register file and shifters
    // ============================================================
    localparam logic [6:0] CHAN = 7'h02, SETUP = 7'h03, MSK = 7'h04, KEY = 7'h05, CFG = 7'h06, ST2 = 7'h07;
    logic [7:0] mem [0:127];
    logic [7:0] sh = 8'h00, inb = 8'h00, ld = 8'h00, key_q = 8'h00;
    logic [6:0] adr = 7'h00;
    logic rd = 1'b0, last = 1'b0, cal_go = 1'b0;
    int cnt = 0;
    // Clamped channel as the radio would use it
    wire [7:0] eff_ch = (mem[CHAN] > 8'h27) ? 8'h27 : mem[CHAN];
    // Channel in use; follows the register only on receive entry
    logic [7:0] rx_ch = 8'h00;
    task automatic go_rx();
        rx_ch = eff_ch;
    endtask
    // Back to reset values; pin polarity active high
    task automatic wipe();
        foreach (mem[i]) mem[i] = 8'h00;
        mem[0] = 8'h01; // Reset-occurred flag
        key_q = 8'h00;
    endtask
    // Store one byte; status clears on ones
    task automatic store(input logic [6:0] a, input logic [7:0] d);
        if (a == 7'h00) mem[0] = mem[0] & ~d;
        else mem[a] = d;
        if (a == KEY && key_q == 8'hb3 && d == 8'h5e) wipe();
        else key_q = (a == KEY) ? d : 8'h00;
        if (a == SETUP && d[0]) cal_go = 1'b1;
    endtask
    initial wipe();
    // Frame start loads the status byte
    always @(negedge csn_i) begin
        cnt = 0;
        sh = mem[0];
    end
    // Sample on rise, act only on whole bytes
    always @(posedge sck_i) if (!csn_i) begin
        inb = {inb[6:0], sdi_i};
        cnt++;
        if (cnt % 8 == 0) begin
            if (cnt == 8) begin
                rd = inb[7];
                adr = inb[6:0];
            end else begin
                if (!rd) store(adr, inb);
                adr++;
            end
            ld = rd ? mem[adr] : mem[0];
        end
    end
    // Data out changes on the falling edge
    always @(negedge sck_i) if (!csn_i) sh = (cnt % 8 == 0) ? ld : {sh[6:0], 1'b0};
    always @(posedge csn_i) last = sh[7];
    // Released line shows the inverse of its last level
    always @* sdo_o = csn_i ? ~last : sh[7];
    // Calibration ends after a while
    always @(posedge cal_go) begin
        #3000;
        mem[SETUP][0] = 1'b0;
        mem[ST2][0] = 1'b1;
        cal_go = 1'b0;
    end
    // Enabled flags drive the pin
    assign irq_o = (|(mem[0] & mem[MSK])) ^ mem[CFG][0];
endmodule
`default_nettype wire

/* verif/radio_spi_host_assertions.sv */
// Port-level checker for the radio serial control port host
`timescale 1ns/1ps
`default_nettype none
module radio_spi_host_assertions (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    // Command port
    input wire logic cmd_valid_i,
    input wire logic cmd_ready_o,
    input wire logic rd_valid_o,
    input wire logic status_valid_o,
    // Interrupt
    input wire logic irq_pin_i,
    input wire logic irq_active_low_i,
    input wire logic irq_o,
    // Serial link
    input wire logic csn_o,
    input wire logic sck_o,
    input wire logic sdi_o
);
    // ============================================================
    // Helper: rising serial clock edges within a frame
    // ============================================================
    logic [9:0] rise_cnt_ff; // Rises counted before this cycle
    logic sck_q_ff; // Serial clock one cycle ago
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rise_cnt_ff <= 10'h000;
            sck_q_ff <= 1'b0;
        end else begin
            sck_q_ff <= sck_o;
            if (csn_o) rise_cnt_ff <= 10'h000;
            else if (sck_o && !sck_q_ff) rise_cnt_ff <= rise_cnt_ff + 10'h001;
        end
    end
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!arst_n_i);
    // ============================================================
    // Properties
    // ============================================================
    a_sck_idle_low: assert property (csn_o |-> !sck_o) else $error("clock moves outside frame");
    a_cs_setup_time: assert property ($fell(csn_o) |-> !sck_o [*4]) else $error("select setup short");
    a_cs_hold_time: assert property ($rose(csn_o) |-> !$past(sck_o, 1) && !$past(sck_o, 4))
        else $error("select hold short");
    a_cs_gap_time: assert property ($rose(csn_o) |-> csn_o [*4]) else $error("select gap short");
    a_take_starts: assert property (cmd_valid_i && cmd_ready_o |=> !csn_o) else $error("frame not started");
    a_busy_no_ready: assert property (!csn_o |-> !cmd_ready_o) else $error("ready during frame");
    a_sdi_at_rise: assert property ($rose(sck_o) |-> $stable(sdi_o)) else $error("data moved at rise");
    a_sck_high_len: assert property ($rose(sck_o) |-> sck_o [*3]) else $error("clock high short");
    a_whole_bytes: assert property ($rose(csn_o) |-> rise_cnt_ff[2:0] == 3'h0 && rise_cnt_ff != 10'h000)
        else $error("partial byte sent");
    a_status_slot: assert property (status_valid_o |-> $rose(sck_o) && rise_cnt_ff == 10'h007)
        else $error("status misplaced");
    a_read_slot: assert property (rd_valid_o |-> $rose(sck_o) && rise_cnt_ff[2:0] == 3'h7 && rise_cnt_ff >= 10'h00f)
        else $error("read byte misplaced");
    a_irq_raised: assert property ((irq_pin_i != irq_active_low_i) [*8] |-> irq_o) else $error("irq missed");
    a_irq_dropped: assert property ((irq_pin_i == irq_active_low_i) [*8] |-> !irq_o) else $error("irq stuck");
endmodule
bind radio_spi_host radio_spi_host_assertions i_chk (.ref_clk_i, .arst_n_i, .cmd_valid_i, .cmd_ready_o,
    .rd_valid_o, .status_valid_o, .irq_pin_i, .irq_active_low_i, .irq_o, .csn_o, .sck_o, .sdi_o);
`default_nettype wire

/* verif/radio_spi_host_tb.sv */
// Self-checking bench for the radio serial control port host
`timescale 1ns/1ps
`default_nettype none
module radio_spi_host_tb;
    // ============================================================
    // Signals
    // ============================================================
    logic ref_clk_i = 1'b0, arst_n_i = 1'b0, cmd_valid_i = 1'b0, cmd_read_i = 1'b0, slow_link_i = 1'b0;
    logic [6:0] cmd_addr_i = 7'h00;
    logic [5:0] cmd_len_i = 6'h00;
    logic [7:0] wr_data_i = 8'h00, rd_data_o, status_o, st;
    logic cmd_ready_o, done_o, wr_take_o, rd_valid_o, status_valid_o, init_done_o, irq_o;
    logic csn_o, sck_o, sdi_o, sdo_i, irq_pin_i;
    logic irq_active_low_i = 1'b0;
    logic [7:0] wq [0:7];
    logic [7:0] rdq [0:7];
    int bad_count = 0, tests_run = 0;
    radio_spi_host i_dut (.ref_clk_i, .arst_n_i, .cmd_valid_i, .cmd_read_i, .cmd_addr_i, .cmd_len_i,
        .slow_link_i, .cmd_ready_o, .done_o, .wr_data_i, .wr_take_o, .rd_data_o, .rd_valid_o, .status_o,
        .status_valid_o, .init_done_o, .irq_pin_i, .irq_active_low_i, .irq_o, .csn_o, .sck_o, .sdi_o, .sdo_i);
    radio_dev_model i_dev (.csn_i(csn_o), .sck_i(sck_o), .sdi_i(sdi_o), .sdo_o(sdo_i), .irq_o(irq_pin_i));
    always #20 ref_clk_i = ~ref_clk_i;
    // ============================================================
    // Shared tasks
    // ============================================================
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Wait a bounded time for a level
    task automatic wait_for(ref logic sig);
        int t = 0;
        while (sig !== 1'b1 && t < 20000) begin
            @(posedge ref_clk_i);
            t++;
        end
        if (sig !== 1'b1) begin
            bad_count++;
            stop_test();
        end
    endtask
    // One user frame; write bytes from wq, read bytes into rdq
    task automatic xfer(input logic rd, input logic [6:0] a, input logic [5:0] n, input logic sl);
        int k = 0;
        int w = 1;
        int t = 0;
        cmd_valid_i <= 1'b1;
        cmd_read_i <= rd;
        cmd_addr_i <= a;
        cmd_len_i <= n;
        slow_link_i <= sl;
        wr_data_i <= wq[0];
        @(posedge ref_clk_i);
        wait_for(cmd_ready_o);
        cmd_valid_i <= 1'b0;
        while (done_o !== 1'b1 && t < 20000) begin
            @(posedge ref_clk_i);
            if (wr_take_o) wr_data_i <= wq[w % 8];
            if (wr_take_o) w++;
            if (rd_valid_o) rdq[k % 8] = rd_data_o;
            if (rd_valid_o) k++;
            if (status_valid_o) st = status_o;
            t++;
        end
        // Frame never finished
        if (done_o !== 1'b1) begin
            bad_count++;
            stop_test();
        end
    endtask
    // ============================================================
    // Scenarios
    // ============================================================
    task automatic t_start();
        wait_for(init_done_o);
        chk("power", i_dev.mem[1], 8'h00);
        chk("channel", i_dev.mem[2], 8'h13);
        xfer(1'b1, 7'h00, 6'h00, 1'b0);
        chk("status", st, 8'h00);
        repeat (100) @(posedge ref_clk_i);
        xfer(1'b1, 7'h03, 6'h05, 1'b1);
        chk("cal request", rdq[0], 8'h00);
        chk("cal done", rdq[4], 8'h01);
        // Out-of-range channel: held until receive entry, then clamped
        wq[0] = 8'h30;
        xfer(1'b0, 7'h02, 6'h01, 1'b0);
        chk("live channel", i_dev.rx_ch, 8'h00);
        i_dev.go_rx();
        chk("clamped channel", i_dev.rx_ch, 8'h27);
    endtask
    task automatic t_write();
        wq[0] = 8'ha5;
        wq[1] = 8'h5a;
        wq[2] = 8'hc3;
        xfer(1'b0, 7'h10, 6'h03, 1'b0);
        for (int i = 0; i < 3; i++) chk("stored", i_dev.mem[16 + i], wq[i]);
        chk("status", st, 8'h00);
        xfer(1'b1, 7'h10, 6'h03, 1'b0);
        for (int i = 0; i < 3; i++) chk("read", rdq[i], wq[i]);
    endtask
    task automatic t_irq();
        i_dev.mem[0] = 8'h06;
        wq[0] = 8'h02;
        xfer(1'b0, 7'h04, 6'h01, 1'b0);
        chk("status", st, 8'h06);
        repeat (10) @(posedge ref_clk_i);
        chk("irq", {7'h00, irq_o}, 8'h01);
        xfer(1'b0, 7'h00, 6'h01, 1'b0);
        chk("cleared", i_dev.mem[0], 8'h04);
        repeat (10) @(posedge ref_clk_i);
        chk("irq", {7'h00, irq_o}, 8'h00);
        // Active-low pin: device polarity bit and host decode flipped together
        wq[0] = 8'h01;
        xfer(1'b0, 7'h06, 6'h01, 1'b0);
        irq_active_low_i <= 1'b1;
        repeat (10) @(posedge ref_clk_i);
        chk("irq inverted idle", {7'h00, irq_o}, 8'h00);
        i_dev.mem[0] = 8'h06;
        repeat (10) @(posedge ref_clk_i);
        chk("irq inverted", {7'h00, irq_o}, 8'h01);
        wq[0] = 8'h02;
        xfer(1'b0, 7'h00, 6'h01, 1'b0);
        repeat (10) @(posedge ref_clk_i);
        chk("irq inverted clear", {7'h00, irq_o}, 8'h00);
        wq[0] = 8'h00;
        xfer(1'b0, 7'h06, 6'h01, 1'b0);
        irq_active_low_i <= 1'b0;
    endtask
    task automatic t_reset();
        wq[0] = 8'hb3;
        xfer(1'b0, 7'h05, 6'h01, 1'b0);
        wq[0] = 8'h5e;
        xfer(1'b0, 7'h05, 6'h01, 1'b0);
        xfer(1'b1, 7'h00, 6'h00, 1'b0);
        chk("reset flag", st, 8'h01);
        chk("wiped", i_dev.mem[16], 8'h00);
    endtask
    initial begin
        repeat (20) @(posedge ref_clk_i);
        arst_n_i <= 1'b1;
        t_start();
        t_write();
        t_irq();
        t_reset();
        stop_test();
    end
endmodule
`default_nettype wire
